// file: shared/bbcr_pkg.sv
package bbcr_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] OFS_B2_CTRL = 8'h06;
  localparam logic [7:0] OFS_BB_CTRL = 8'h07;

  // ****************************************
  // field positions
  // ****************************************
  localparam int BIT_RSVD       = 7;
  localparam int BIT_B2_EN      = 6;
  localparam int BIT_B2_FPWM    = 5;
  // buck-boost, default layout: force-PWM above enable
  localparam int BIT_BB_FPWM_TB = 6;
  localparam int BIT_BB_EN_TB   = 5;
  // buck-boost, alternate layout: enable above force-PWM
  localparam int BIT_BB_EN_PR   = 6;
  localparam int BIT_BB_FPWM_PR = 5;
  localparam int VCODE_MSB      = 4;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic       RST_B2_EN   = 1'b1;
  localparam logic       RST_B2_FPWM = 1'b0;
  localparam logic       RST_BB_EN   = 1'b1;
  localparam logic       RST_BB_FPWM = 1'b0;
  localparam logic [4:0] RST_VCODE   = 5'h00;

  // ****************************************
  // voltage decode, millivolts
  // ****************************************
  localparam logic [11:0] MV_BASE     = 12'h708;
  localparam logic [11:0] MV_B2_STEP  = 12'h064;
  localparam logic [11:0] MV_BB_STEP  = 12'h032;
  localparam logic [11:0] MV_TOP      = 12'hce4;
  localparam logic [11:0] MV_NONE     = 12'h000;
  localparam logic [4:0]  B2_TOP_CODE = 5'h10;
endpackage

// file: core/bbcr_regs.sv
// Functional notes
// - second buck register bit D6 enables the converter and resets to 1.
// - second buck bit D5 forces PWM when 1, auto modulation when 0, reset 0.
// - second buck code 0 is external, 1..15 give 1.80..3.20 V, else 3.30 V.
// - power-on sequencing enables the buck-boost without a register write.
// - the buck-boost stays off whenever its code is zero.
// - the pull-down is on while the buck-boost is off, but off for code 0.
// - the buck-boost code comes out of reset as a factory default.
// - buck-boost code 0 is off, 1..31 give 1.80..3.30 V in 50 mV steps.
// - the default buck-boost layout has force-PWM at D6, enable at D5.
// - codes change live while running; force-PWM only when the bit is 1.
module bbcr_regs #(
  // 1: buck-boost force-PWM at D6, enable at D5; 0: the two swapped
  parameter bit BB_TABLE_LAYOUT = 1'b1
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        srst,
  // factory defaults, same clock domain
  input  wire logic [4:0]  fuse_b2_vcode,
  input  wire logic [4:0]  fuse_bb_vcode,
  // power-on sequencer
  input  wire logic        seq_bb_enable,
  // register port from the serial engine
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  output logic             regs_ready,
  // second step-down converter controls
  output logic             b2_enable,
  output logic             b2_force_pwm,
  output logic      [4:0]  b2_vcode,
  output logic             b2_ext_ctrl,
  output logic      [11:0] b2_mv,
  // buck-boost controls
  output logic             bb_enable,
  output logic             bb_force_pwm,
  output logic      [4:0]  bb_vcode,
  output logic             bb_pulldown,
  output logic      [11:0] bb_mv
);

  localparam int BB_EN_BIT   = BB_TABLE_LAYOUT ? bbcr_pkg::BIT_BB_EN_TB
                                               : bbcr_pkg::BIT_BB_EN_PR;
  localparam int BB_FPWM_BIT = BB_TABLE_LAYOUT ? bbcr_pkg::BIT_BB_FPWM_TB
                                               : bbcr_pkg::BIT_BB_FPWM_PR;

  // ****************************************
  // decode functions
  // ****************************************
  function automatic logic [11:0] b2_decode(input logic [4:0] c);
    logic [11:0] steps;
    steps = {7'h00, c} - 12'h001;
    if (c == 5'h00) begin
      b2_decode = bbcr_pkg::MV_NONE;
    end else if (c >= bbcr_pkg::B2_TOP_CODE) begin
      b2_decode = bbcr_pkg::MV_TOP;
    end else begin
      b2_decode = 12'(bbcr_pkg::MV_BASE + steps * bbcr_pkg::MV_B2_STEP);
    end
  endfunction

  function automatic logic [11:0] bb_decode(input logic [4:0] c);
    logic [11:0] steps;
    steps = {7'h00, c} - 12'h001;
    if (c == 5'h00) begin
      bb_decode = bbcr_pkg::MV_NONE;
    end else begin
      bb_decode = 12'(bbcr_pkg::MV_BASE + steps * bbcr_pkg::MV_BB_STEP);
    end
  endfunction

  // ****************************************
  // register state
  // ****************************************
  logic       loaded_ff;
  logic       b2_en_ff;
  logic       b2_fpwm_ff;
  logic [4:0] b2_code_ff;
  logic       bb_en_ff;
  logic       bb_fpwm_ff;
  logic [4:0] bb_code_ff;
  logic [7:0] rdata_ff;
  logic       wr_b2;
  logic       wr_bb;
  logic       bb_on;

  assign wr_b2 = reg_wr && loaded_ff && (reg_addr == bbcr_pkg::OFS_B2_CTRL);
  assign wr_bb = reg_wr && loaded_ff && (reg_addr == bbcr_pkg::OFS_BB_CTRL);
  assign regs_ready = loaded_ff;

  // fuses are sampled on the first edge after release, not inside reset
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      loaded_ff <= 1'b0;
    end else begin
      loaded_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      b2_en_ff <= bbcr_pkg::RST_B2_EN;
    end else if (wr_b2) begin
      b2_en_ff <= reg_wdata[bbcr_pkg::BIT_B2_EN];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      b2_fpwm_ff <= bbcr_pkg::RST_B2_FPWM;
    end else if (wr_b2) begin
      b2_fpwm_ff <= reg_wdata[bbcr_pkg::BIT_B2_FPWM];
    end
  end

  // codes are rewritable at any time, enabled or not
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      b2_code_ff <= bbcr_pkg::RST_VCODE;
    end else if (!loaded_ff) begin
      b2_code_ff <= fuse_b2_vcode;
    end else if (wr_b2) begin
      b2_code_ff <= reg_wdata[bbcr_pkg::VCODE_MSB:0];
    end
  end

  // sequencer set wins over a same-cycle clear by software
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      bb_en_ff <= bbcr_pkg::RST_BB_EN;
    end else if (seq_bb_enable) begin
      bb_en_ff <= 1'b1;
    end else if (wr_bb) begin
      // enable position follows the chosen layout
      bb_en_ff <= reg_wdata[BB_EN_BIT];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      bb_fpwm_ff <= bbcr_pkg::RST_BB_FPWM;
    end else if (wr_bb) begin
      bb_fpwm_ff <= reg_wdata[BB_FPWM_BIT];
    end
  end

  // factory default loaded right after reset
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      bb_code_ff <= bbcr_pkg::RST_VCODE;
    end else if (!loaded_ff) begin
      bb_code_ff <= fuse_bb_vcode;
    end else if (wr_bb) begin
      bb_code_ff <= reg_wdata[bbcr_pkg::VCODE_MSB:0];
    end
  end

  // ****************************************
  // read path
  // ****************************************
  // reserved bit and unmapped offsets read zero
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      rdata_ff <= 8'h00;
      if (reg_addr == bbcr_pkg::OFS_B2_CTRL) begin
        rdata_ff[bbcr_pkg::BIT_B2_EN]   <= b2_en_ff;
        rdata_ff[bbcr_pkg::BIT_B2_FPWM] <= b2_fpwm_ff;
        rdata_ff[bbcr_pkg::VCODE_MSB:0] <= b2_code_ff;
      end else if (reg_addr == bbcr_pkg::OFS_BB_CTRL) begin
        rdata_ff[BB_EN_BIT]             <= bb_en_ff;
        rdata_ff[BB_FPWM_BIT]           <= bb_fpwm_ff;
        rdata_ff[bbcr_pkg::VCODE_MSB:0] <= bb_code_ff;
      end
    end
  end
  assign reg_rdata = rdata_ff;

  // ****************************************
  // converter control outputs
  // ****************************************
  // zero code overrides the enable bit
  assign bb_on = bb_en_ff && (bb_code_ff != 5'h00);

  // second buck outputs, one cycle behind the register
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      b2_enable    <= bbcr_pkg::RST_B2_EN;
      b2_force_pwm <= bbcr_pkg::RST_B2_FPWM;
      b2_vcode     <= bbcr_pkg::RST_VCODE;
      b2_ext_ctrl  <= 1'b1;
      b2_mv        <= bbcr_pkg::MV_NONE;
    end else begin
      b2_enable    <= b2_en_ff;
      b2_force_pwm <= b2_fpwm_ff;
      b2_vcode     <= b2_code_ff;
      // code 0 hands voltage to the external control
      b2_ext_ctrl  <= (b2_code_ff == 5'h00);
      b2_mv        <= b2_decode(b2_code_ff);
    end
  end

  // reset keeps the converter off until the fuse code is known
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      bb_enable    <= 1'b0;
      bb_force_pwm <= bbcr_pkg::RST_BB_FPWM;
      bb_vcode     <= bbcr_pkg::RST_VCODE;
      bb_pulldown  <= 1'b0;
      bb_mv        <= bbcr_pkg::MV_NONE;
    end else begin
      bb_enable    <= bb_on;
      bb_force_pwm <= bb_fpwm_ff;
      bb_vcode     <= bb_code_ff;
      // pull-down off when code is zero
      bb_pulldown  <= !bb_on && (bb_code_ff != 5'h00);
      // 50 mV steps from 1.80 V
      bb_mv        <= bb_decode(bb_code_ff);
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  sequence s_b2_write;
    reg_wr && loaded_ff && reg_addr == bbcr_pkg::OFS_B2_CTRL;
  endsequence

  sequence s_bb_read;
    reg_rd && reg_addr == bbcr_pkg::OFS_BB_CTRL;
  endsequence

  a_b2_en_write: assert property (s_b2_write |-> ##2
    b2_enable == $past(reg_wdata[bbcr_pkg::BIT_B2_EN], 2))
    else $error("second buck enable not taken from write");

  a_b2_fpwm_write: assert property (s_b2_write |-> ##2
    b2_force_pwm == $past(reg_wdata[bbcr_pkg::BIT_B2_FPWM], 2))
    else $error("second buck force pwm not taken from write");

  a_b2_top_code: assert property (b2_code_ff[4] |=>
    b2_mv == bbcr_pkg::MV_TOP)
    else $error("second buck upper codes not 3.30 V");

  // code checked after the set edge: a same-cycle write may zero it
  a_seq_bb_set: assert property (seq_bb_enable ##1 bb_code_ff != 5'h00
    |-> ##1 bb_enable)
    else $error("sequencer did not enable buck-boost");

  a_bb_zero_off: assert property (bb_code_ff == 5'h00 |=>
    !bb_enable && !bb_pulldown)
    else $error("buck-boost on or pulled down at code zero");

  a_bb_pulldown: assert property (!bb_en_ff && bb_code_ff != 5'h00
    |=> bb_pulldown && !bb_enable)
    else $error("pull-down missing while buck-boost off");

  a_bb_fuse_load: assert property ($rose(loaded_ff) |->
    bb_code_ff == $past(fuse_bb_vcode))
    else $error("buck-boost code not loaded from fuses");

  a_bb_decode: assert property (bb_code_ff == 5'h1f |=>
    bb_mv == bbcr_pkg::MV_TOP)
    else $error("buck-boost top code not 3.30 V");

  a_bb_layout: assert property (s_bb_read ##1 loaded_ff
    |-> reg_rdata[BB_EN_BIT] == $past(bb_en_ff))
    else $error("buck-boost enable read at wrong bit");

  a_rsvd_zero: assert property (reg_rd |=>
    reg_rdata[bbcr_pkg::BIT_RSVD] == 1'b0)
    else $error("reserved bit read non-zero");

  // running before and after the write: enable bit kept set
  a_code_live: assert property (s_b2_write ##0 b2_en_ff
    && reg_wdata[bbcr_pkg::BIT_B2_EN] |-> ##2
    b2_vcode == $past(reg_wdata[bbcr_pkg::VCODE_MSB:0], 2) && b2_enable)
    else $error("second buck code change not applied while running");

endmodule

// file: verif/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk_sys = 1'b0;
  logic        srst = 1'b1;
  logic [4:0]  fuse_b2_vcode = 5'h05;
  logic [4:0]  fuse_bb_vcode = 5'h1f;
  logic        seq_bb_enable = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_rdata;
  logic        regs_ready;
  logic        b2_enable;
  logic        b2_force_pwm;
  logic [4:0]  b2_vcode;
  logic        b2_ext_ctrl;
  logic [11:0] b2_mv;
  logic        bb_enable;
  logic        bb_force_pwm;
  logic [4:0]  bb_vcode;
  logic        bb_pulldown;
  logic [11:0] bb_mv;
  int          num_errors = 0;
  int          total_checks = 0;
  logic [7:0]  rdat;
  logic [4:0]  codes [5] = '{5'h00, 5'h01, 5'h0f, 5'h10, 5'h1f};

  bbcr_regs uut (
    .clk_sys(clk_sys), .srst(srst),
    .fuse_b2_vcode(fuse_b2_vcode), .fuse_bb_vcode(fuse_bb_vcode),
    .seq_bb_enable(seq_bb_enable),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .regs_ready(regs_ready),
    .b2_enable(b2_enable), .b2_force_pwm(b2_force_pwm),
    .b2_vcode(b2_vcode), .b2_ext_ctrl(b2_ext_ctrl), .b2_mv(b2_mv),
    .bb_enable(bb_enable), .bb_force_pwm(bb_force_pwm),
    .bb_vcode(bb_vcode), .bb_pulldown(bb_pulldown), .bb_mv(bb_mv)
  );

  // alternate buck-boost layout, watched through its read data only
  bbcr_regs #(.BB_TABLE_LAYOUT(1'b0)) uut_alt (
    .clk_sys(clk_sys), .srst(srst),
    .fuse_b2_vcode(fuse_b2_vcode), .fuse_bb_vcode(fuse_bb_vcode),
    .seq_bb_enable(seq_bb_enable),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(rdat), .regs_ready(),
    .b2_enable(), .b2_force_pwm(), .b2_vcode(), .b2_ext_ctrl(), .b2_mv(),
    .bb_enable(), .bb_force_pwm(), .bb_vcode(), .bb_pulldown(), .bb_mv()
  );

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input string name, input logic [11:0] exp,
                     input logic [11:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("[ERR] %s exp %h got %h", name, exp, got);
      num_errors++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
    // controls land one edge after the edge that takes the write
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk("rdata", {4'h0, exp}, {4'h0, reg_rdata});
  endtask

  function automatic logic [11:0] b2mv(input logic [4:0] c);
    if (c == 5'h00) return 12'h000;
    if (c >= 5'h10) return 12'hce4;
    return 12'h708 + (12'(c) - 12'h001) * 12'h064;
  endfunction

  function automatic logic [11:0] bbmv(input logic [4:0] c);
    if (c == 5'h00) return 12'h000;
    return 12'h708 + (12'(c) - 12'h001) * 12'h032;
  endfunction

  task automatic bbchk(input logic en, input logic pd, input logic fp);
    chk("bb_enable", {11'h0, en}, {11'h0, bb_enable});
    chk("bb_pulldown", {11'h0, pd}, {11'h0, bb_pulldown});
    chk("bb_force_pwm", {11'h0, fp}, {11'h0, bb_force_pwm});
  endtask

  task automatic close_out;
    if (num_errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ****************************************
  // watchdog
  // ****************************************
  initial begin
    #50us;
    num_errors++;
    close_out();
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (8) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    chk("regs_ready", 12'h001, {11'h0, regs_ready});
    chk("b2_enable", 12'h001, {11'h0, b2_enable});
    chk("b2_force_pwm", 12'h000, {11'h0, b2_force_pwm});
    chk("bb_vcode", 12'h01f, {7'h0, bb_vcode});
    chk("bb_mv", 12'hce4, bb_mv);
    bbchk(1'b1, 1'b0, 1'b0);
    rd(8'h06, 8'h45);
    rd(8'h07, 8'h3f);
    chk("rdata_alt", 12'h05f, {4'h0, rdat});
    wr(8'h06, 8'h25);
    chk("b2_enable", 12'h000, {11'h0, b2_enable});
    chk("b2_force_pwm", 12'h001, {11'h0, b2_force_pwm});
    chk("b2_mv", 12'h898, b2_mv);
    foreach (codes[i]) begin
      wr(8'h06, {3'b010, codes[i]});
      chk("b2_mv", b2mv(codes[i]), b2_mv);
      chk("b2_vcode", {7'h0, codes[i]}, {7'h0, b2_vcode});
      chk("b2_ext", {11'h0, codes[i] == 5'h00}, {11'h0, b2_ext_ctrl});
      wr(8'h07, {3'b001, codes[i]});
      chk("bb_mv", bbmv(codes[i]), bb_mv);
    end
    wr(8'h06, 8'hc3);
    rd(8'h06, 8'h43);
    wr(8'h07, 8'h20);
    bbchk(1'b0, 1'b0, 1'b0);
    // code first, then force-PWM, then the enable bit
    wr(8'h07, 8'h0a);
    bbchk(1'b0, 1'b1, 1'b0);
    wr(8'h07, 8'h4a);
    bbchk(1'b0, 1'b1, 1'b1);
    wr(8'h07, 8'h2a);
    bbchk(1'b1, 1'b0, 1'b0);
    wr(8'h07, 8'h8a);
    rd(8'h07, 8'h0a);
    @(posedge clk_sys);
    seq_bb_enable <= 1'b1;
    @(posedge clk_sys);
    seq_bb_enable <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    bbchk(1'b1, 1'b0, 1'b0);
    rd(8'h07, 8'h2a);
    chk("rdata_alt", 12'h04a, {4'h0, rdat});
    wr(8'h08, 8'hff);
    rd(8'h08, 8'h00);
    rd(8'h06, 8'h43);
    close_out();
  end
endmodule
